// [rtl/icc_pkg.sv]
// Package of constants and types for the input capture channel
package icc_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ICC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] ICC_OFS_STAT   = 8'h04;
  localparam logic [7:0] ICC_OFS_FIFO   = 8'h08;
  localparam logic [7:0] ICC_OFS_IRQST  = 8'h0C;
  localparam logic [7:0] ICC_OFS_IRQMSK = 8'h10;

  // ---------------------------------------------------------------
  // Field layout and sizes
  // ---------------------------------------------------------------
  localparam int ICC_NTIMERS  = 6;
  localparam int ICC_TW       = 16;
  localparam int ICC_DEPTH    = 4;
  localparam int ICC_PW       = 2;
  localparam int ICC_CW       = 3;
  localparam int ICC_NIRQ     = 2;
  localparam int ICC_IRQ_CAP  = 0;
  localparam int ICC_IRQ_OVF  = 1;
  localparam int ICC_ST_NE    = 0;
  localparam int ICC_ST_OVF   = 1;
  localparam int ICC_ST_CNT   = 4;
  localparam logic [3:0] ICC_PRE4  = 4'h3;
  localparam logic [3:0] ICC_PRE16 = 4'hF;
  localparam logic [ICC_CW-1:0] ICC_CNT_FULL = 3'h4;
  localparam logic [ICC_CW-1:0] ICC_CNT_ONE  = 3'h1;
  localparam logic [ICC_PW-1:0] ICC_PTR_ONE  = 2'h1;
  localparam logic [1:0] ICC_HTRANS_NONSEQ = 2'h2;

  // Capture modes
  typedef enum logic [1:0] {
    ICC_MODE_OFF   = 2'h0,
    ICC_MODE_EVERY = 2'h1,
    ICC_MODE_PRE4  = 2'h2,
    ICC_MODE_PRE16 = 2'h3
  } icc_mode_e;

  // Control register: bits 0 on, 2:1 mode, 3 first rising, 4 wide,
  // 7:5 timer select, 9:8 fill level minus one, 10 wake enable
  typedef struct packed {
    logic       wake_en;
    logic [1:0] fill_lvl;
    logic [2:0] tmr_sel;
    logic       wide;
    logic       first_rise;
    icc_mode_e  mode;
    logic       on;
  } icc_ctrl_s;
  localparam int ICC_CTRL_W = 11;

  // AHB-Lite slave request
  typedef struct packed {
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } icc_ahb_req_s;

  // AHB-Lite slave response
  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } icc_ahb_rsp_s;

endpackage

// [rtl/icc_input_capture.sv]
// Input capture channel with four-word FIFO and AHB-Lite registers
//
// Operation
// - Qualifying pin event latches the selected time base, 16 or 32 bits.
// - Every-edge mode captures both edges, starting on the configured polarity.
// - Prescaled modes capture every fourth or sixteenth rising edge.
// - Software selects the time base from six 16-bit timers.
// - Wide mode cascades two timers into one 32-bit base.
// - Capture event can wake the device from Sleep or Idle.
// - Capture events can raise an interrupt request.
// - Captures queue oldest first in a four-word FIFO.
// - Capture interrupt after one, two, three or four entries filled.
// - Pin and interrupt work as an extra external interrupt source.
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
module icc_input_capture
  import icc_pkg::*;
(
  // Clock, reset and enable
  input  wire logic                                sys_clk,
  input  wire logic                                rst,
  input  wire logic                                clk_en,
  // Capture pin and timer bases
  input  wire logic                                capture_input_pin,
  input  wire logic [icc_pkg::ICC_NTIMERS*icc_pkg::ICC_TW-1:0] timer_counts,
  // Low-power state of the device
  input  wire logic                                low_power,
  // Register bus
  input  wire icc_pkg::icc_ahb_req_s               ahb_req,
  output icc_pkg::icc_ahb_rsp_s                    ahb_rsp,
  // Interrupt and wake request
  output logic                                     irq,
  output logic                                     wake_req
);
  import icc_pkg::*;

  // Every-edge qualifier: wait for the start polarity, then take all edges
  typedef enum logic [1:0] {
    ICC_ARM_WAIT = 2'b01,
    ICC_ARM_ALL  = 2'b10
  } icc_arm_e;

  // ---------------------------------------------------------------
  // Pin synchroniser and edge detection
  // ---------------------------------------------------------------
  logic                        pin_s1_r;
  logic                        pin_s2_r;
  logic                        pin_d_r;
  logic                        rise;
  logic                        fall;
  icc_ctrl_s                   ctrl_r;
  logic [3:0]                  pre_r;
  icc_arm_e                    arm_r;
  logic                        event_hit;
  logic [31:0]                 tb_val;
  logic [ICC_TW-1:0]           tmr_w [ICC_NTIMERS];
  logic [31:0]                 fifo_r [ICC_DEPTH];
  logic [ICC_PW-1:0]           wptr_r;
  logic [ICC_PW-1:0]           rptr_r;
  logic [ICC_CW-1:0]           cnt_r;
  logic                        ovf_r;
  logic [ICC_NIRQ-1:0]         irq_st_r;
  logic [ICC_NIRQ-1:0]         irq_msk_r;
  logic                        fill_hit;
  logic                        drop;
  logic [ICC_NIRQ-1:0]         irq_set;
  logic [ICC_NIRQ-1:0]         irq_st_nxt;
  logic                        push;
  logic                        pop;
  logic                        ph_valid_r;
  logic                        ph_write_r;
  logic [7:0]                  ph_addr_r;
  logic                        acc;
  logic                        rd_fifo;
  logic                        rd_irqst;
  logic                        wr_stat;
  logic [31:0]                 rdata_nxt;
  logic [31:0]                 rdata_r;

  // Two flops before any logic, third for edge history
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_d_r  <= 1'b0;
    end else if (clk_en) begin
      pin_s1_r <= capture_input_pin;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  assign rise = pin_s2_r & ~pin_d_r;
  assign fall = ~pin_s2_r & pin_d_r;

  // ---------------------------------------------------------------
  // Event qualification
  // ---------------------------------------------------------------
  // First edge must match the start polarity; afterwards every edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      arm_r <= ICC_ARM_WAIT;
    end else if (clk_en) begin
      if (!ctrl_r.on || ctrl_r.mode != ICC_MODE_EVERY) begin
        arm_r <= ICC_ARM_WAIT; // Re-armed whenever the mode is left
      end else begin
        unique case (arm_r)
          ICC_ARM_WAIT: begin
            if (ctrl_r.first_rise ? rise : fall) begin
              arm_r <= ICC_ARM_ALL;
            end
          end
          ICC_ARM_ALL:  arm_r <= ICC_ARM_ALL;
          default:      arm_r <= ICC_ARM_WAIT;
        endcase
      end
    end
  end

  // Rising edge prescaler, cleared while off or outside the two prescaled modes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pre_r <= 4'h0;
    end else if (clk_en) begin
      if (!ctrl_r.on || ctrl_r.mode == ICC_MODE_EVERY || ctrl_r.mode == ICC_MODE_OFF) begin
        pre_r <= 4'h0;
      end else if (rise) begin
        if ((ctrl_r.mode == ICC_MODE_PRE4 && pre_r == ICC_PRE4) ||
            (ctrl_r.mode == ICC_MODE_PRE16 && pre_r == ICC_PRE16)) begin
          pre_r <= 4'h0;
        end else begin
          pre_r <= pre_r + 4'h1;
        end
      end
    end
  end

  // Qualifying event per mode
  always_comb begin
    event_hit = 1'b0;
    if (ctrl_r.on) begin
      unique case (ctrl_r.mode)
        ICC_MODE_OFF:   event_hit = 1'b0;
        ICC_MODE_EVERY: event_hit = (arm_r == ICC_ARM_ALL) ? (rise | fall)
                                            : (ctrl_r.first_rise ? rise : fall);
        ICC_MODE_PRE4:  event_hit = rise && pre_r == ICC_PRE4;
        ICC_MODE_PRE16: event_hit = rise && pre_r == ICC_PRE16;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Time base selection
  // ---------------------------------------------------------------
  // One word per timer, split from the timer bus
  for (genvar t = 0; t < ICC_NTIMERS; t++) begin : g_tmr
    assign tmr_w[t] = timer_counts[t*ICC_TW +: ICC_TW];
  end

  // Narrow: one timer; wide: selected timer low half, next timer high, timer 0 after the last.
  // Selects beyond the last timer name no timer and capture zero
  always_comb begin
    logic [2:0] hi_sel;
    hi_sel = 3'h0;
    tb_val = 32'h0000_0000;
    if (ctrl_r.tmr_sel < 3'(ICC_NTIMERS)) begin
      tb_val[ICC_TW-1:0] = tmr_w[ctrl_r.tmr_sel];
      hi_sel = (ctrl_r.tmr_sel == 3'(ICC_NTIMERS-1)) ? 3'h0 : ctrl_r.tmr_sel + 3'h1;
      if (ctrl_r.wide) begin
        tb_val[31:ICC_TW] = tmr_w[hi_sel];
      end
    end
  end

  // ---------------------------------------------------------------
  // Capture FIFO
  // ---------------------------------------------------------------
  // A full FIFO refuses the push; the event then only flags overflow
  assign push = event_hit && cnt_r != ICC_CNT_FULL;
  assign pop  = rd_fifo && cnt_r != 3'h0;
  assign drop = event_hit && cnt_r == ICC_CNT_FULL;

  // One word per entry, written when the write index selects it
  for (genvar e = 0; e < ICC_DEPTH; e++) begin : g_entry
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        fifo_r[e] <= 32'h0000_0000;
      end else if (clk_en && push && wptr_r == ICC_PW'(e)) begin
        fifo_r[e] <= tb_val;
      end
    end
  end

  // Write index advances on each accepted capture; switching off flushes
  always_ff @(posedge sys_clk) begin
    if (rst || (clk_en && !ctrl_r.on)) begin
      wptr_r <= '0;
    end else if (clk_en && push) begin
      wptr_r <= wptr_r + ICC_PTR_ONE;
    end
  end

  // Read index advances on each pop; switching off flushes
  always_ff @(posedge sys_clk) begin
    if (rst || (clk_en && !ctrl_r.on)) begin
      rptr_r <= '0;
    end else if (clk_en && pop) begin
      rptr_r <= rptr_r + ICC_PTR_ONE;
    end
  end

  // Fill count; a push and a pop together leave it unchanged
  always_ff @(posedge sys_clk) begin
    if (rst || (clk_en && !ctrl_r.on)) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      if (push && !pop) begin
        cnt_r <= cnt_r + ICC_CNT_ONE;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - ICC_CNT_ONE;
      end
    end
  end

  // Sticky overflow; a new drop wins over a clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ovf_r <= 1'b0;
    end else if (clk_en) begin
      if (drop) begin
        ovf_r <= 1'b1;
      end else if (rd_fifo || (wr_stat && ahb_req.hwdata[ICC_ST_OVF])) begin
        ovf_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupts and wake
  // ---------------------------------------------------------------
  // Fill level reached on the push that makes count one above the field
  assign fill_hit             = push && (cnt_r == {1'b0, ctrl_r.fill_lvl});
  assign irq_set[ICC_IRQ_CAP] = fill_hit;
  assign irq_set[ICC_IRQ_OVF] = drop;

  // Per status bit: a read clears, but a set in the same cycle wins
  for (genvar b = 0; b < ICC_NIRQ; b++) begin : g_irq
    assign irq_st_nxt[b] = irq_set[b] | (irq_st_r[b] & ~rd_irqst);
  end

  // Sticky status register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_st_r <= '0;
    end else if (clk_en) begin
      irq_st_r <= irq_st_nxt;
    end
  end

  assign irq = |(irq_st_r & irq_msk_r);

  // Wake pulse on any qualifying event while in low power;
  // registered so the power controller sees a clean single-cycle pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wake_req <= 1'b0;
    end else if (clk_en) begin
      wake_req <= event_hit && low_power && ctrl_r.wake_en;
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  // Address phase captured when the bus is ready
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_addr_r  <= 8'h00;
    end else if (clk_en && ahb_req.hready) begin
      ph_valid_r <= ahb_req.hsel && ahb_req.htrans == ICC_HTRANS_NONSEQ;
      ph_write_r <= ahb_req.hwrite;
      ph_addr_r  <= ahb_req.haddr;
    end
  end

  // Reads act in the address phase, writes in the data phase
  assign acc      = clk_en && ahb_req.hready && ahb_req.hsel &&
                    ahb_req.htrans == ICC_HTRANS_NONSEQ;
  assign rd_fifo  = acc && !ahb_req.hwrite && ahb_req.haddr == ICC_OFS_FIFO;
  assign rd_irqst = acc && !ahb_req.hwrite && ahb_req.haddr == ICC_OFS_IRQST;
  assign wr_stat  = clk_en && ph_valid_r && ph_write_r && ph_addr_r == ICC_OFS_STAT;

  // Writable registers take data in the data phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r    <= '0;
      irq_msk_r <= '0;
    end else if (clk_en && ph_valid_r && ph_write_r) begin
      if (ph_addr_r == ICC_OFS_CTRL) begin
        ctrl_r <= icc_ctrl_s'(ahb_req.hwdata[ICC_CTRL_W-1:0]);
      end
      if (ph_addr_r == ICC_OFS_IRQMSK) begin
        irq_msk_r <= ahb_req.hwdata[ICC_NIRQ-1:0];
      end
    end
  end

  // Read data sampled in the address phase, unmapped reads zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (ahb_req.haddr)
      ICC_OFS_CTRL:   rdata_nxt[ICC_CTRL_W-1:0] = ctrl_r;
      ICC_OFS_STAT: begin
        rdata_nxt[ICC_ST_NE]  = cnt_r != 3'h0;
        rdata_nxt[ICC_ST_OVF] = ovf_r;
        rdata_nxt[ICC_ST_CNT +: ICC_CW] = cnt_r;
      end
      ICC_OFS_FIFO:   rdata_nxt = (cnt_r != 3'h0) ? fifo_r[rptr_r] : 32'h0000_0000;
      ICC_OFS_IRQST:  rdata_nxt[ICC_NIRQ-1:0] = irq_st_r;
      ICC_OFS_IRQMSK: rdata_nxt[ICC_NIRQ-1:0] = irq_msk_r;
      default:        rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read word registered so hrdata stands until the next read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (acc && !ahb_req.hwrite) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Zero wait states, always OKAY
  assign ahb_rsp.hrdata    = rdata_r;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp     = 1'b0;

endmodule

// [verif/icc_assertions.sv]
// Checker of the input capture channel ports
`timescale 1ns/100ps
module icc_assertions
  import icc_pkg::*;
(
  // Clock, reset and enable
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire logic                  clk_en,
  // Pin and power state
  input wire logic                  capture_input_pin,
  input wire logic                  low_power,
  // Bus and outputs
  input wire icc_pkg::icc_ahb_req_s ahb_req,
  input wire icc_pkg::icc_ahb_rsp_s ahb_rsp,
  input wire logic                  irq,
  input wire logic                  wake_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic       pin_q;
  logic [3:0] quiet_r;
  logic       take;
  logic       rd_take;
  logic       wr_take;
  // Bus phases taken, and cycles since the pin last moved
  assign take    = ahb_req.hsel & ahb_req.hready & clk_en & (ahb_req.htrans == ICC_HTRANS_NONSEQ);
  assign rd_take = take & ~ahb_req.hwrite;
  assign wr_take = take & ahb_req.hwrite;
  always_ff @(posedge sys_clk) pin_q <= capture_input_pin;
  always_ff @(posedge sys_clk) begin
    if (rst || pin_q != capture_input_pin) quiet_r <= 4'h0;
    else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
  end
  sequence s_pin_recent;
    quiet_r <= 4'h6;
  endsequence
  sequence s_no_read;
    !rd_take;
  endsequence
  property p_wake_lp;
    wake_req |-> $past(low_power) || $past(low_power, 2);
  endproperty
  a_wake_lp: assert property (p_wake_lp) else $error("wake outside low power");
  property p_wake_pulse;
    wake_req && clk_en |=> !wake_req;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than a pulse");
  property p_wake_cause;
    wake_req |-> s_pin_recent;
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake with a quiet pin");
  property p_rst_quiet;
    $past(rst) |-> !irq && !wake_req;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");
  property p_irq_cause;
    $rose(irq) |-> quiet_r <= 4'h6 || $past(wr_take, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
  property p_freeze;
    !clk_en |=> $stable(irq) && $stable(wake_req);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
  property p_bus_okay;
    ahb_rsp.hreadyout && !ahb_rsp.hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or error");
  property p_rdata_hold;
    s_no_read |=> $stable(ahb_rsp.hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule
bind icc_input_capture icc_assertions i_chk (.*);

// [verif/icc_pin_model.sv]
// Behavioural model of the signal on the capture pin
`timescale 1ns/100ps
module icc_pin_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Request: toggle count and cycles per level
  input  wire logic       go,
  input  wire logic [5:0] n,
  input  wire logic [3:0] hold,
  // Pin and activity
  output logic            pin,
  output logic            busy
);
  logic [5:0] left_r = 6'h0;
  logic [3:0] cnt_r  = 4'h0;
  logic       pin_r  = 1'b0;
  // Each level stands hold cycles, so the synchroniser sees it
  always @(posedge sys_clk) begin
    if (rst) begin
      pin_r  <= 1'b0;
      left_r <= 6'h0;
    end else if (go) begin
      left_r <= n;
      cnt_r  <= hold;
    end else if (left_r != 6'h0) begin
      if (cnt_r <= 4'h1) begin
        pin_r  <= ~pin_r;
        left_r <= left_r - 6'h1;
        cnt_r  <= hold;
      end else begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
  assign pin  = pin_r;
  assign busy = go | (left_r != 6'h0);
endmodule

// [verif/test_icc_input_capture.sv]
// Testbench for the input capture channel
`timescale 1ns/100ps
module test_icc_input_capture;
  import icc_pkg::*;
  logic         sys_clk   = 1'b0;
  logic         rst       = 1'b1;
  logic         clk_en    = 1'b1;
  logic         low_power = 1'b0;
  logic         pgo       = 1'b0;
  logic [5:0]   pn        = 6'h0;
  logic [3:0]   phold     = 4'h2;
  logic [95:0]  tmr       = '0;
  icc_ahb_req_s req       = '0;
  icc_ahb_req_s bus_req;
  icc_ahb_rsp_s rsp;
  logic         pin;
  logic         pbusy;
  logic         irq;
  logic         wake_req;
  logic [31:0]  q;
  int           err_total = 0;
  int           num_checks = 0;
  int           wake_n = 0;
  // Clock, ready loop-back and wake pulse count
  always #2.5 sys_clk = ~sys_clk;
  always_comb begin
    bus_req        = req;
    bus_req.hready = rsp.hreadyout;
  end
  always @(posedge sys_clk) if (wake_req === 1'b1) wake_n++;
  icc_input_capture i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .capture_input_pin(pin), .timer_counts(tmr), .low_power(low_power),
    .ahb_req(bus_req), .ahb_rsp(rsp), .irq(irq), .wake_req(wake_req));
  icc_pin_model i_pin (.sys_clk(sys_clk), .rst(rst), .go(pgo), .n(pn),
    .hold(phold), .pin(pin), .busy(pbusy));
  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single word transfer; waits bounded
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req.hsel <= 1'b1;
    req.haddr <= a;
    req.htrans <= ICC_HTRANS_NONSEQ;
    req.hwrite <= w;
    req.hsize <= 3'h2;
    do begin @(posedge sys_clk); n++; end while (rsp.hreadyout !== 1'b1 && n < 50);
    req.htrans <= 2'h0;
    req.hsel <= 1'b0;
    req.hwdata <= d;
    do begin @(posedge sys_clk); n++; end while (rsp.hreadyout !== 1'b1 && n < 50);
    q = rsp.hrdata;
    if (n >= 50) begin err_total++; conclude(); end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic ck_irq(input logic e);
    @(posedge sys_clk);
    chk(irq, e);
  endtask
  // Ask the pin model for n toggles, then let the capture settle
  task automatic edges(input logic [5:0] n, input logic [3:0] h);
    int k;
    k = 0;
    pn <= n;
    phold <= h;
    pgo <= 1'b1;
    @(posedge sys_clk);
    pgo <= 1'b0;
    do begin @(posedge sys_clk); k++; end while (pbusy && k < 600);
    repeat (8) @(posedge sys_clk);
    if (k >= 600) begin err_total++; conclude(); end
  endtask
  task automatic set_tmr(input logic [15:0] b);
    for (int k = 0; k < 6; k++) tmr[16*k +: 16] <= b + 16'(k);
  endtask
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ICC_OFS_CTRL, 32'h0);
    rd(ICC_OFS_STAT, 32'h0);
    rd(8'h14, 32'h0);
    chk(irq, 1'b0);
    $display("test reset done");
    set_tmr(16'h1000);
    bus(1'b1, ICC_OFS_CTRL, 32'h43);
    edges(6'h1, 4'h6);
    set_tmr(16'h2000);
    edges(6'h1, 4'h6);
    set_tmr(16'h3000);
    edges(6'h1, 4'h6);
    rd(ICC_OFS_STAT, 32'h21);
    rd(ICC_OFS_FIFO, 32'h2002);
    rd(ICC_OFS_FIFO, 32'h3002);
    rd(ICC_OFS_STAT, 32'h0);
    rd(ICC_OFS_FIFO, 32'h0);
    $display("test every edge done");
    set_tmr(16'h4000);
    for (int s = 0; s < 6; s++) begin
      bus(1'b1, ICC_OFS_CTRL, 32'h0);
      bus(1'b1, ICC_OFS_CTRL, {24'h0, 3'(s), 1'b1, ~pin, 3'h3});
      edges(6'h1, 4'h3);
      rd(ICC_OFS_FIFO, {16'h4000 + 16'((s + 1) % 6), 16'h4000 + 16'(s)});
    end
    $display("test wide base done");
    for (int m = 2; m < 4; m++) begin
      bus(1'b1, ICC_OFS_CTRL, 32'h0);
      bus(1'b1, ICC_OFS_CTRL, {29'h0, 2'(m), 1'b1});
      edges(m == 2 ? 6'h10 : 6'h20, 4'h2);
      rd(ICC_OFS_STAT, m == 2 ? 32'h21 : 32'h11);
    end
    $display("test prescale done");
    bus(1'b1, ICC_OFS_IRQMSK, 32'h3);
    for (int f = 0; f < 4; f++) begin
      bus(1'b1, ICC_OFS_CTRL, 32'h0);
      bus(1'b1, ICC_OFS_CTRL, {22'h0, 2'(f), 4'h0, ~pin, 3'h3});
      for (int k = 1; k < 5; k++) begin
        edges(6'h1, 4'h2);
        chk(irq, k > f);
      end
      edges(6'h1, 4'h2);
      rd(ICC_OFS_STAT, 32'h43);
      bus(1'b1, ICC_OFS_IRQMSK, 32'h0);
      ck_irq(1'b0);
      bus(1'b1, ICC_OFS_IRQMSK, 32'h3);
      ck_irq(1'b1);
      rd(ICC_OFS_IRQST, 32'h3);
      ck_irq(1'b0);
      rd(ICC_OFS_FIFO, 32'h4000);
      rd(ICC_OFS_STAT, 32'h31);
    end
    $display("test fill and overflow done");
    bus(1'b1, ICC_OFS_CTRL, 32'h0);
    bus(1'b1, ICC_OFS_CTRL, {21'h0, 1'b1, 6'h0, ~pin, 3'h3});
    low_power <= 1'b1;
    edges(6'h2, 4'h4);
    chk(wake_n, 2);
    low_power <= 1'b0;
    edges(6'h1, 4'h4);
    chk(wake_n, 2);
    clk_en <= 1'b0;
    repeat (5) @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(ICC_OFS_STAT, 32'h31);
    $display("test wake done");
    conclude();
  end
endmodule
